// ---- core/hbs_defs.svh ----
// constants of the host bus strobe decode front end
// assumes a 200 MHz core clock and a plain software register port
`ifndef HBS_DEFS_SVH
`define HBS_DEFS_SVH

// ****************************************************
// software register offsets
// ****************************************************
`define HBS_OFS_CTRL    8'h00
`define HBS_OFS_STATUS  8'h04
`define HBS_OFS_MASK    8'h08
`define HBS_OFS_STRAP   8'h0c
`define HBS_OFS_LAST    8'h10

// ****************************************************
// field positions and reset values
// ****************************************************
`define HBS_CTRL_POL_HIGH  0
`define HBS_CTRL_PULSE     1
`define HBS_CTRL_PIN_VAL   2
`define HBS_CTRL_RST       3'h1
`define HBS_EVT_W          3
`define HBS_EVT_RST        3'h0
`define HBS_LAST_DATA_LSB  8

// ****************************************************
// widths and timing
// ****************************************************
`define HBS_AD_W           8
`define HBS_DATA_W         16
`define HBS_SYNC_W         30
`define HBS_STRAP_WAIT     2'h3
`define HBS_CLK_MHZ        200
`define HBS_IRQ_PULSE_NS   100
`define HBS_IRQ_PULSE_CYC \
    ((`HBS_IRQ_PULSE_NS * `HBS_CLK_MHZ + 999) / 1000)
`define HBS_PCNT_W         5

`endif

// ---- core/hbs_pkg.sv ----
// types shared by the host bus strobe decode front end
// assumes hbs_defs.svh is on the include path
`include "hbs_defs.svh"

package hbs_pkg;

    // power-up strap choices
    typedef struct packed {
        logic latchSelStyle;   // 1: addr/data select, 0: latch strobe
        logic strobeStyle;     // 1: read/write strobes, 0: dir plus strobe
    } hbs_strap_t;

    // software control fields
    typedef struct packed {
        logic pinVal;          // strap pin level after power-up
        logic pulseMode;       // 1: fixed pulse, 0: held level
        logic polHigh;         // 1: active high interrupt line
    } hbs_ctrl_t;

    // host-side events: read start, data write, address capture
    typedef struct packed {
        logic hostRead;
        logic dataWrite;
        logic addrCapture;
    } hbs_evt_t;

    typedef enum logic [1:0] {
        IRQ_IDLE,
        IRQ_PULSE,
        IRQ_WAIT
    } hbs_irq_state_t;

endpackage

// ---- core/hbs_sync.sv ----
// two-flop synchroniser bank for asynchronous pin inputs
// assumes clk and an active low asynchronous reset of that domain
`timescale 1ns/1ps

module hbs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstN,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);

    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule

// ---- core/hbs_host_port.sv ----
// parallel host port front end: strap capture, strobe decode,
// address/data split, two-way buses, interrupt line and soft registers
// assumes host pins are asynchronous to clk; internal register file
// and software port run on clk
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps

module hbs_host_port
    import hbs_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // software register port
    input  wire logic [7:0]              swAddr,
    input  wire logic [31:0]             swWrData,
    input  wire logic                    swWr,
    input  wire logic                    swRd,
    output logic      [31:0]             swRdData,
    output logic                         swIrq,
    // host pins
    input  wire logic                    csPin_n,
    input  wire logic                    dirOrRdPin,
    input  wire logic                    strobeOrWrPin,
    input  wire logic                    latchOrSelPin,
    input  wire logic [`HBS_AD_W-1:0]    adIn,
    output logic      [`HBS_AD_W-1:0]    adOut,
    output logic                         adOe,
    input  wire logic [`HBS_DATA_W-1:0]  dataIn,
    output logic      [`HBS_DATA_W-1:0]  dataOut,
    output logic                         dataOe,
    output logic                         irqLine,
    output logic                         readyOut,
    input  wire logic                    strobeStylePinIn,
    output logic                         strobeStylePinOut,
    output logic                         strobeStylePinOe,
    input  wire logic                    addrLatchStylePin,
    // internal register file side
    output logic      [`HBS_AD_W-1:0]    regAddr,
    output logic      [`HBS_DATA_W-1:0]  regWrData,
    output logic                         regWrPulse,
    output logic                         regRdPulse,
    input  wire logic [`HBS_DATA_W-1:0]  regRdData,
    input  wire logic                    regBusy
);

    // ****************************************************
    // reset release
    // ****************************************************
    logic [1:0] rstPipe_q;
    logic       rstN;
    // asynchronous assert, two-flop release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_q <= 2'h0;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstN = rstPipe_q[1];

    // ****************************************************
    // pin synchronisers
    // ****************************************************
    logic [`HBS_SYNC_W-1:0] pinRaw;
    logic [`HBS_SYNC_W-1:0] pinSync;
    logic                   csN_s;
    logic                   p26_s;
    logic                   p27_s;
    logic                   p29_s;
    logic [`HBS_AD_W-1:0]   ad_s;
    logic [`HBS_DATA_W-1:0] data_s;
    hbs_strap_t             strap_s;
    assign pinRaw = {csPin_n, dirOrRdPin, strobeOrWrPin, latchOrSelPin,
                     adIn, dataIn, addrLatchStylePin, strobeStylePinIn};
    hbs_sync #(
        .W       (`HBS_SYNC_W)
    ) u_sync (
        .clk     (clk),
        .rstN    (rstN),
        .asyncIn (pinRaw),
        .syncOut (pinSync)
    );
    assign {csN_s, p26_s, p27_s, p29_s, ad_s, data_s, strap_s} = pinSync;

    // ****************************************************
    // power-up strap capture
    // ****************************************************
    logic [1:0] strapCnt_q;
    logic       strapDone_q;
    hbs_strap_t strap_q;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            strapCnt_q  <= 2'h0;
            strapDone_q <= 1'b0;
            strap_q     <= '0;
        end else if (!strapDone_q) begin
            strapCnt_q <= strapCnt_q + 2'h1;
            if (strapCnt_q == `HBS_STRAP_WAIT) begin
                strap_q     <= strap_s;
                strapDone_q <= 1'b1;
            end
        end
    end

    // ****************************************************
    // previous-sample copies for edge detection
    // ****************************************************
    logic                   csN_q;
    logic                   p26_q;
    logic                   p27_q;
    logic                   p29_q;
    logic [`HBS_AD_W-1:0]   ad_q;
    logic [`HBS_DATA_W-1:0] data_q;
    // one-cycle history of synchronised pins
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            csN_q  <= 1'b1;
            p26_q  <= 1'b1;
            p27_q  <= 1'b1;
            p29_q  <= 1'b0;
            ad_q   <= '0;
            data_q <= '0;
        end else begin
            csN_q  <= csN_s;
            p26_q  <= p26_s;
            p27_q  <= p27_s;
            p29_q  <= p29_s;
            ad_q   <= ad_s;
            data_q <= data_s;
        end
    end

    // ****************************************************
    // strobe decode
    // ****************************************************
    logic readActive;
    logic readActive_q;
    logic readStart;
    logic writeEdge;
    logic latchFall;
    logic selAddrWrite;
    logic dataWrite;
    // pin 26/27 meaning per strobe style
    assign readActive = strapDone_q && !csN_s &&
        (strap_q.strobeStyle ? !p26_s : (!p27_s && p26_s));
    assign readStart  = readActive && !readActive_q;
    assign writeEdge  = strapDone_q && !csN_q && !p27_q && p27_s &&
        (strap_q.strobeStyle || !p26_q);
    assign latchFall    = strapDone_q && !strap_q.latchSelStyle &&
                          p29_q && !p29_s;
    assign selAddrWrite = writeEdge && strap_q.latchSelStyle && p29_q;
    assign dataWrite    = writeEdge && !selAddrWrite;

    // ****************************************************
    // internal register file side
    // ****************************************************
    // address capture from muxed bus
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            regAddr <= '0;
        end else if (latchFall || selAddrWrite) begin
            regAddr <= ad_q;
        end
    end

    // write data from muxed or data bus
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            regWrData  <= '0;
            regWrPulse <= 1'b0;
        end else begin
            regWrPulse <= dataWrite;
            if (dataWrite) begin
                regWrData <= strap_q.latchSelStyle ?
                    {{(`HBS_DATA_W-`HBS_AD_W){1'b0}}, ad_q} : data_q;
            end
        end
    end

    // read pulse and ready flag
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            regRdPulse   <= 1'b0;
            readActive_q <= 1'b0;
            readyOut     <= 1'b0;
        end else begin
            regRdPulse   <= readStart;
            readActive_q <= readActive;
            readyOut     <= strapDone_q && !regBusy && !writeEdge;
        end
    end

    // ****************************************************
    // two-way buses
    // ****************************************************
    // drive only during host reads
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            dataOut <= '0;
            adOut   <= '0;
            dataOe  <= 1'b0;
            adOe    <= 1'b0;
        end else begin
            dataOe  <= readActive;
            adOe    <= readActive && strap_q.latchSelStyle;
            dataOut <= regRdData;
            adOut   <= regRdData[`HBS_AD_W-1:0];
        end
    end

    // ****************************************************
    // software registers
    // ****************************************************
    hbs_ctrl_t ctrl_q;
    hbs_evt_t  status_q;
    hbs_evt_t  mask_q;
    hbs_evt_t  evt;
    assign evt = '{hostRead: readStart, dataWrite: dataWrite,
                   addrCapture: latchFall || selAddrWrite};

    // control register
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ctrl_q <= `HBS_CTRL_RST;
        end else if (swWr && swAddr == `HBS_OFS_CTRL) begin
            ctrl_q <= swWrData[`HBS_CTRL_PIN_VAL:`HBS_CTRL_POL_HIGH];
        end
    end

    // sticky status, write one clears, set wins
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            status_q <= `HBS_EVT_RST;
        end else if (swWr && swAddr == `HBS_OFS_STATUS) begin
            status_q <= (status_q & ~swWrData[`HBS_EVT_W-1:0]) | evt;
        end else begin
            status_q <= status_q | evt;
        end
    end

    // interrupt mask
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            mask_q <= `HBS_EVT_RST;
        end else if (swWr && swAddr == `HBS_OFS_MASK) begin
            mask_q <= swWrData[`HBS_EVT_W-1:0];
        end
    end

    // read data one cycle after strobe, zero otherwise
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            swRdData <= '0;
        end else if (!swRd) begin
            swRdData <= '0;
        end else begin
            case (swAddr)
                `HBS_OFS_CTRL:   swRdData <= {29'h0, ctrl_q};
                `HBS_OFS_STATUS: swRdData <= {29'h0, status_q};
                `HBS_OFS_MASK:   swRdData <= {29'h0, mask_q};
                `HBS_OFS_STRAP:  swRdData <= {29'h0, strapDone_q, strap_q};
                `HBS_OFS_LAST:   swRdData <= {8'h0, regWrData, regAddr};
                default:         swRdData <= '0;
            endcase
        end
    end

    // ****************************************************
    // strap pin reuse as output
    // ****************************************************
    // output after sampling
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            strobeStylePinOut <= 1'b0;
            strobeStylePinOe  <= 1'b0;
        end else begin
            strobeStylePinOut <= ctrl_q.pinVal;
            strobeStylePinOe  <= strapDone_q;
        end
    end

    // ****************************************************
    // interrupt line
    // ****************************************************
    logic                  irqRaw;
    logic                  irqRaw_q;
    logic                  irqActive;
    logic [`HBS_PCNT_W-1:0] pulseCnt_q;
    hbs_irq_state_t        irqState_q;
    assign irqRaw = |(status_q & mask_q);
    assign swIrq  = irqRaw;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            irqState_q <= IRQ_IDLE;
            pulseCnt_q <= '0;
            irqRaw_q   <= 1'b0;
        end else begin
            irqRaw_q <= irqRaw;
            case (irqState_q)
                IRQ_IDLE: begin
                    if (ctrl_q.pulseMode && irqRaw && !irqRaw_q) begin
                        irqState_q <= IRQ_PULSE;
                        pulseCnt_q <= `HBS_PCNT_W'(`HBS_IRQ_PULSE_CYC - 1);
                    end
                end
                IRQ_PULSE: begin
                    if (pulseCnt_q == '0) begin
                        irqState_q <= IRQ_WAIT;
                    end else begin
                        pulseCnt_q <= pulseCnt_q - 1'b1;
                    end
                end
                IRQ_WAIT: begin
                    if (!irqRaw) begin
                        irqState_q <= IRQ_IDLE;
                    end
                end
                default: irqState_q <= IRQ_IDLE;
            endcase
        end
    end

    assign irqActive = ctrl_q.pulseMode ? (irqState_q == IRQ_PULSE)
                                        : irqRaw;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            irqLine <= 1'b0;
        end else begin
            irqLine <= ctrl_q.polHigh ? irqActive : !irqActive;
        end
    end

endmodule

// ---- verif/hbs_host_port_sva.sv ----
// checker for the host port: bus enables, strap hold, interrupt shape
// assumes it is bound to hbs_host_port and sees only its ports
`timescale 1ns/1ps
`include "hbs_defs.svh"

module hbs_host_port_sva (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire logic [7:0]             swAddr,
    input wire logic [31:0]            swWrData,
    input wire logic                   swWr,
    input wire logic                   swIrq,
    input wire logic                   csPin_n,
    input wire logic                   strobeOrWrPin,
    input wire logic [`HBS_AD_W-1:0]   adOut,
    input wire logic                   adOe,
    input wire logic [`HBS_DATA_W-1:0] dataOut,
    input wire logic                   dataOe,
    input wire logic                   irqLine,
    input wire logic                   readyOut,
    input wire logic                   strobeStylePinOe,
    input wire logic                   regWrPulse,
    input wire logic [`HBS_DATA_W-1:0] regRdData
);
    logic pol_q;
    logic pulse_q;

    // ****************************************
    // mirror of the interrupt control fields
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pol_q   <= 1'b1;
            pulse_q <= 1'b0;
        end else if (swWr && swAddr == `HBS_OFS_CTRL) begin
            pol_q   <= swWrData[`HBS_CTRL_POL_HIGH];
            pulse_q <= swWrData[`HBS_CTRL_PULSE];
        end
    end

    default clocking cbk @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ****************************************
    // assertions
    // ****************************************
    chk_oe_pair: assert property (adOe |-> dataOe)
        else $error("muxed bus driven without data read");
    chk_oe_idle: assert property (
        csPin_n [*6] |-> !dataOe && !adOe)
        else $error("bus driven while deselected");
    chk_data_follow: assert property (
        dataOe && $past(dataOe) |-> dataOut == $past(regRdData))
        else $error("data port not following read data");
    chk_ad_follow: assert property (
        adOe && $past(adOe) |-> adOut == $past(regRdData[7:0]))
        else $error("muxed bus not following read data");
    chk_wr_pulse: assert property (
        regWrPulse |-> $past(strobeOrWrPin) ##1 !regWrPulse)
        else $error("write pulse without strobe rise");
    chk_strap_hold: assert property (
        strobeStylePinOe |=> strobeStylePinOe)
        else $error("strap pin output dropped");
    chk_ready_strap: assert property (
        readyOut |-> strobeStylePinOe)
        else $error("ready before strap capture");
    chk_irq_level: assert property (
        !pulse_q && !$past(pulse_q) && !$past(pulse_q, 2) |->
        irqLine == ($past(pol_q) ? $past(swIrq) : !$past(swIrq)))
        else $error("interrupt level or polarity wrong");
    chk_irq_pulse: assert property (
        pulse_q && pol_q && $rose(irqLine) |-> ##19 irqLine ##1 !irqLine)
        else $error("interrupt pulse width wrong");
endmodule

bind hbs_host_port hbs_host_port_sva u_sva (
    .clk(clk), .rst_n(rst_n), .swAddr(swAddr), .swWrData(swWrData),
    .swWr(swWr), .swIrq(swIrq), .csPin_n(csPin_n),
    .strobeOrWrPin(strobeOrWrPin), .adOut(adOut), .adOe(adOe),
    .dataOut(dataOut), .dataOe(dataOe), .irqLine(irqLine),
    .readyOut(readyOut), .strobeStylePinOe(strobeStylePinOe),
    .regWrPulse(regWrPulse), .regRdData(regRdData));

// ---- verif/hbs_host_bfm.sv ----
// host processor model for the parallel port, one task per bus cycle
// assumes the bench resolves both two-way buses and calls the tasks
`timescale 1ns/1ps

module hbs_host_bfm (
    input  wire logic        clk,
    input  wire logic [7:0]  adBus,
    input  wire logic [15:0] dataBus,
    output logic             csN,
    output logic             dirRd,
    output logic             strobeWr,
    output logic             latchSel,
    output logic [7:0]       adDrv,
    output logic [15:0]      dataDrv
);
    logic rwStyle;  // 1: separate strobes, 0: direction plus strobe

    initial begin
        rwStyle  = 1'b1;
        csN      = 1'b1;
        dirRd    = 1'b1;
        strobeWr = 1'b1;
        latchSel = 1'b0;
        adDrv    = 8'h00;
        dataDrv  = 16'h0000;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ****************************************
    // bus cycles, latch and write phases held 6 clocks, read phases 8 clocks
    // ****************************************
    // latch falling edge
    task automatic latch(input logic [7:0] a);
        csN      <= 1'b0;
        adDrv    <= a;
        latchSel <= 1'b1;
        idle(6);
        latchSel <= 1'b0;
        idle(6);
        csN   <= 1'b1;
        adDrv <= ~a;  // released bus shows no stale value
        idle(6);
    endtask

    task automatic put(input logic [7:0] a, input logic [15:0] d,
                       input logic sel);
        csN      <= 1'b0;
        dirRd    <= rwStyle;  // low direction means write
        adDrv    <= a;
        dataDrv  <= d;
        latchSel <= sel;
        idle(6);
        strobeWr <= 1'b0;
        idle(6);
        strobeWr <= 1'b1;  // rising edge takes the write
        idle(6);
        csN     <= 1'b1;
        adDrv   <= ~a;
        dataDrv <= ~d;
        latchSel <= 1'b0;
        idle(6);
    endtask

    task automatic get(output logic [7:0] a, output logic [15:0] d);
        csN      <= 1'b0;
        dirRd    <= !rwStyle;  // read strobe low or direction high
        strobeWr <= rwStyle;   // data strobe low in direction style
        idle(8);
        a = adBus;
        d = dataBus;
        csN      <= 1'b1;
        dirRd    <= 1'b1;
        strobeWr <= 1'b1;
        idle(8);
    endtask
endmodule

// ---- verif/tb_host_bus_strobe_decode.sv ----
// self-checking bench for the host port front end
// assumes the design files and the host model are compiled first
`timescale 1ns/1ps
`include "hbs_defs.svh"

module tb_host_bus_strobe_decode;
    logic        clk, rst_n, swWr, swRd, swIrq, strapA, strapB, regBusy;
    logic        csN, dirRd, strobeWr, latchSel, adOe, dataOe, irqLine;
    logic        readyOut, pinIn, pinOut, pinOe, regWrPulse, rdPulse;
    logic [7:0]  swAddr, adDrv, adOut, adIn, regAddr, ra;
    logic [15:0] dataDrv, dataOut, dataIn, regWrData, regRdData, rd;
    logic [31:0] swWrData, swRdData, seed;
    int          badCount, cmpCount, wrPulses, rdPulses, n;
    logic [31:0] expQ[$];

    // two-way buses and strap pin resolved from all enables
    assign adIn   = adOe ? adOut : adDrv;
    assign dataIn = dataOe ? dataOut : dataDrv;
    assign pinIn  = pinOe ? pinOut : strapA;

    hbs_host_port u_dut (
        .clk(clk), .rst_n(rst_n), .swAddr(swAddr), .swWrData(swWrData),
        .swWr(swWr), .swRd(swRd), .swRdData(swRdData), .swIrq(swIrq),
        .csPin_n(csN), .dirOrRdPin(dirRd), .strobeOrWrPin(strobeWr),
        .latchOrSelPin(latchSel), .adIn(adIn), .adOut(adOut), .adOe(adOe),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
        .irqLine(irqLine), .readyOut(readyOut), .strobeStylePinIn(pinIn),
        .strobeStylePinOut(pinOut), .strobeStylePinOe(pinOe),
        .addrLatchStylePin(strapB), .regAddr(regAddr),
        .regWrData(regWrData), .regWrPulse(regWrPulse), .regRdPulse(rdPulse),
        .regRdData(regRdData), .regBusy(regBusy));

    hbs_host_bfm u_host (
        .clk(clk), .adBus(adIn), .dataBus(dataIn), .csN(csN),
        .dirRd(dirRd), .strobeWr(strobeWr), .latchSel(latchSel),
        .adDrv(adDrv), .dataDrv(dataDrv));

    // ****************************************
    // clock, pulse counter, watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (regWrPulse === 1'b1) wrPulses++;
        if (rdPulse === 1'b1) rdPulses++;
    end

    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        endSim();
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        cmpCount++;
        if (s !== e) begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic swWrite(input logic [7:0] a, input logic [31:0] d);
        swAddr   <= a;
        swWrData <= d;
        swWr     <= 1'b1;
        @(posedge clk);
        swWr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic swRead(input logic [7:0] a, input logic [31:0] e);
        swAddr <= a;
        swRd   <= 1'b1;
        @(posedge clk);
        swRd <= 1'b0;
        @(posedge clk);
        chk("sw read", e, swRdData);
    endtask

    task automatic doReset(input logic s0, input logic s1);
        strapA <= s0;
        strapB <= s1;
        rst_n  <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (12) @(posedge clk);
    endtask

    task automatic endSim();
        $display("comparisons %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        {swWr, swRd, regBusy, strapB} = 4'h0;
        strapA    = 1'b1;
        swAddr    = 8'h00;
        swWrData  = 32'h00000000;
        regRdData = 16'h0000;
        seed      = 32'h0001526b;
        doReset(1'b1, 1'b0);
        swRead(`HBS_OFS_STRAP, 32'h00000005);
        chk("strap pin oe", 32'h00000001, pinOe);
        strapA <= 1'b0;
        strapB <= 1'b1;
        repeat (8) @(posedge clk);
        swRead(`HBS_OFS_STRAP, 32'h00000005);
        $display("test straps done");
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            u_host.latch(seed[7:0]);
            chk("reg addr", seed[7:0], regAddr);
            u_host.put(8'h00, seed[23:8], 1'b0);
            expQ.push_back({8'h00, seed[23:8], seed[7:0]});
            chk("reg data", seed[23:8], regWrData);
            swRead(`HBS_OFS_LAST, expQ.pop_front());
            regRdData <= seed[31:16];
            u_host.get(ra, rd);
            chk("read data", seed[31:16], rd);
        end
        chk("write pulses", 32'h00000003, wrPulses);
        $display("test latch style done");
        swWrite(`HBS_OFS_MASK, 32'h00000001);
        repeat (3) @(posedge clk);
        chk("irq level high", 32'h00000001, irqLine);
        swWrite(`HBS_OFS_CTRL, 32'h00000000);
        repeat (3) @(posedge clk);
        chk("irq level low", 32'h00000000, irqLine);
        swWrite(`HBS_OFS_STATUS, 32'h00000007);
        repeat (3) @(posedge clk);
        chk("irq idle", 32'h00000001, irqLine);
        swWrite(`HBS_OFS_CTRL, 32'h00000007);
        swWrite(8'h40, 32'hffffffff);
        swRead(8'h40, 32'h00000000);
        chk("strap pin out", 32'h00000001, pinOut);
        n = 0;
        fork
            u_host.latch(8'h5a);
            repeat (60) begin
                @(posedge clk);
                if (irqLine === 1'b1) n++;
            end
        join
        chk("irq pulse", `HBS_IRQ_PULSE_CYC, n);
        regBusy <= 1'b1;
        repeat (3) @(posedge clk);
        chk("ready busy", 32'h00000000, readyOut);
        regBusy <= 1'b0;
        repeat (3) @(posedge clk);
        chk("ready idle", 32'h00000001, readyOut);
        $display("test interrupt done");
        doReset(1'b0, 1'b1);
        u_host.rwStyle = 1'b0;
        swRead(`HBS_OFS_STRAP, 32'h00000006);
        seed = lfsr(seed);
        u_host.put(seed[7:0], 16'h0000, 1'b1);
        chk("sel addr", seed[7:0], regAddr);
        u_host.put(seed[15:8], 16'hffff, 1'b0);
        chk("sel data", seed[15:8], regWrData);
        regRdData <= seed[31:16];
        u_host.get(ra, rd);
        chk("sel read ad", seed[23:16], ra);
        chk("sel read data", seed[31:16], rd);
        $display("test select style done");
        chk("read pulses", 32'h00000004, rdPulses);
        endSim();
    end
endmodule
